// ### rtl/cfg_map_pkg.sv
package cfg_map_pkg;
  // ********************************************************
  // variable numbers and widths
  // ********************************************************
  localparam int CV_NUM_W = 9;
  localparam logic [8:0] CV_PAGE_HIGH = 9'h01f;
  localparam logic [8:0] CV_PAGE_LOW = 9'h020;
  localparam logic [8:0] CV_LOAD_INF = 9'h038;
  localparam logic [8:0] CV_FEATURE = 9'h07c;
  localparam logic [8:0] CV_LOW_LAST = 9'h100;
  localparam logic [8:0] CV_WIN_FIRST = 9'h101;
  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] PAGE_HIGH_RST = 8'h10;
  localparam logic [7:0] PAGE_LOW_RST = 8'h00;
  localparam logic [7:0] LOAD_INF_RST = 8'hff;
  localparam logic [7:0] FEATURE_RST = 8'h14;
  // ********************************************************
  // paging and mapping layout
  // ********************************************************
  localparam logic [7:0] PAGE_HIGH_MAP = 8'h10;
  localparam logic [7:0] PAGE_LOW_LAST = 8'h04;
  localparam logic [2:0] MAP_PAGE_FIRST = 3'h2;
  localparam int NUM_PAGES = 5;
  localparam int PAGE_BYTES = 256;
  localparam int NUM_ROWS = 32;
  localparam int ROW_STRIDE = 16;
  localparam int COND_VARS = 9;
  localparam logic [3:0] OUT_VAR_PHYS = 4'h9;
  localparam int OUT_VARS = 5;
  localparam logic [7:0] LOAD_INF_FULL = 8'hff;
  localparam int SERIAL_EN_BIT = 3;
  // ********************************************************
  // conditions and outputs
  // ********************************************************
  localparam int NUM_KEYS = 29;
  localparam int NUM_SENSORS = 5;
  localparam int NUM_COND = 36;
  localparam int COND_MOVING = 0;
  localparam int COND_FWD = 1;
  localparam int COND_KEY0 = 2;
  localparam int COND_SENSOR0 = 31;
  localparam int NUM_OUTPUTS = 6;
  localparam int OUT_FRONT = 0;
  localparam int OUT_REAR = 1;
  localparam int OUT_AUX_OUTPUT_ONE = 2;
  localparam int OUT_AUX2 = 3;
  localparam int OUT_AUX3 = 4;
  localparam int OUT_AUX_OUTPUT_FOUR = 5;
  // default lighting rows: forward or reverse with key zero on
  localparam logic [7:0] ROW1_COND_RST = 8'h14;
  localparam logic [7:0] ROW1_OUT_RST = 8'h01;
  localparam logic [7:0] ROW2_COND_RST = 8'h18;
  localparam logic [7:0] ROW2_OUT_RST = 8'h02;
endpackage

// ### rtl/cfg_map_store.sv
// Behaviour
// - variables 257 to 511 form a paged window selected by index registers
// - both index variables together choose the page seen in the window
// - variables 1 to 256 always reach the same storage
// - aux output four on while stopped and moving either way when mapped
// - bit 3 of variable 124 enables the serial extension link
// - variable 56 scales load control from none to full compensation
// - six physical outputs: front, rear and four auxiliary
// - key zero is the lighting key by default
// - one key drives many outputs, one output driven by many keys
// - several key conditions in a row combine as logical and
// - inverted conditions hold only while the key is off
// - keys 0 to 28, direction and moving state are conditions
// - five external sensor inputs are conditions too
// - output allocation may differ for forward and reverse
// - 32 rows scanned first to last, actions of each hit row applied
// - each row has nine condition variables and one output variable
// - each condition variable holds four on/off bit pairs
module cfg_map_store
  import cfg_map_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // variable access from the command path
  input wire logic [CV_NUM_W-1:0] cv_num_i,
  input wire logic cv_wr_i,
  input wire logic cv_rd_i,
  input wire logic [7:0] cv_wdata_i,
  output logic [7:0] cv_rdata_o,
  output logic cv_ack_o,
  // mapping conditions
  input wire logic [NUM_KEYS-1:0] fkey_i,
  input wire logic moving_i,
  input wire logic forward_i,
  input wire logic [NUM_SENSORS-1:0] sensor_i,
  // load control
  input wire logic [15:0] load_corr_i,
  output logic [15:0] load_corr_o,
  // physical outputs and links
  output logic front_light_o,
  output logic rear_light_o,
  output logic aux_output_one_o,
  output logic aux_output_two_o,
  output logic aux_output_three_o,
  output logic aux_output_four_o,
  output logic serial_extension_link_o
);

  // ********************************************************
  // decode
  // ********************************************************
  function automatic logic in_window(input logic [CV_NUM_W-1:0] num);
    in_window = (num >= CV_WIN_FIRST);
  endfunction

  function automatic logic in_low(input logic [CV_NUM_W-1:0] num);
    in_low = (num != '0) && (num <= CV_LOW_LAST);
  endfunction

  logic [7:0] page_high_reg;
  logic [7:0] page_low_reg;
  logic [7:0] load_inf_reg;
  logic [7:0] feature_reg;
  logic [7:0] low_mem [0:PAGE_BYTES-1];
  logic [7:0] win_mem [0:NUM_PAGES*PAGE_BYTES-1];
  logic win_ok;
  logic [10:0] win_addr;
  logic [7:0] low_addr;
  logic [7:0] win_cur;

  assign win_ok = (page_high_reg == PAGE_HIGH_MAP) && (page_low_reg <= PAGE_LOW_LAST);
  assign win_addr = {page_low_reg[2:0], 8'(cv_num_i - CV_WIN_FIRST)};
  assign low_addr = 8'(cv_num_i - 9'h001);
  assign win_cur = win_mem[win_addr];

  // ********************************************************
  // index and setting variables
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      page_high_reg <= PAGE_HIGH_RST;
      page_low_reg <= PAGE_LOW_RST;
      load_inf_reg <= LOAD_INF_RST;
      feature_reg <= FEATURE_RST;
    end else if (cv_wr_i) begin
      if (cv_num_i == CV_PAGE_HIGH) begin
        page_high_reg <= cv_wdata_i;
      end else if (cv_num_i == CV_PAGE_LOW) begin
        page_low_reg <= cv_wdata_i;
      end else if (cv_num_i == CV_LOAD_INF) begin
        load_inf_reg <= cv_wdata_i;
      end else if (cv_num_i == CV_FEATURE) begin
        feature_reg <= cv_wdata_i;
      end
    end
  end

  // ********************************************************
  // low storage
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        low_mem[i] <= 8'h00;
      end
    end else if (cv_wr_i && in_low(cv_num_i)) begin
      low_mem[low_addr] <= cv_wdata_i;
    end
  end

  // ********************************************************
  // paged storage
  // ********************************************************
  // reset clears every page, then seeds the lighting rows
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_PAGES * PAGE_BYTES; i++) begin
        win_mem[i] <= 8'h00;
      end
      // key zero lights front or rear by direction
      win_mem[{MAP_PAGE_FIRST, 4'h0, 4'h0}] <= ROW1_COND_RST;
      win_mem[{MAP_PAGE_FIRST, 4'h0, OUT_VAR_PHYS}] <= ROW1_OUT_RST;
      win_mem[{MAP_PAGE_FIRST, 4'h1, 4'h0}] <= ROW2_COND_RST;
      win_mem[{MAP_PAGE_FIRST, 4'h1, OUT_VAR_PHYS}] <= ROW2_OUT_RST;
    end else if (cv_wr_i && in_window(cv_num_i) && win_ok) begin
      win_mem[win_addr] <= cv_wdata_i;
    end
  end

  // ********************************************************
  // read and acknowledge
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cv_rdata_o <= 8'h00;
      cv_ack_o <= 1'b0;
    end else begin
      cv_ack_o <= cv_rd_i || cv_wr_i;
      if (cv_rd_i) begin
        if (cv_num_i == CV_PAGE_HIGH) begin
          cv_rdata_o <= page_high_reg;
        end else if (cv_num_i == CV_PAGE_LOW) begin
          cv_rdata_o <= page_low_reg;
        end else if (cv_num_i == CV_LOAD_INF) begin
          cv_rdata_o <= load_inf_reg;
        end else if (cv_num_i == CV_FEATURE) begin
          cv_rdata_o <= feature_reg;
        end else if (in_low(cv_num_i)) begin
          cv_rdata_o <= low_mem[low_addr];
        end else if (in_window(cv_num_i) && win_ok) begin
          cv_rdata_o <= win_cur;
        end else begin
          // unmapped pages read as zero so stale data is never shown
          cv_rdata_o <= 8'h00;
        end
      end
    end
  end

  // ********************************************************
  // mapping scan
  // ********************************************************
  logic [NUM_COND-1:0] cond;
  logic [2*NUM_COND-1:0] sat;
  logic [8*COND_VARS-1:0] row_mask;
  logic [4:0] row_reg;
  logic [2:0] row_page;
  logic [7:0] row_out;
  logic row_hit;
  logic [NUM_OUTPUTS-1:0] acc_reg;
  logic [NUM_OUTPUTS-1:0] outputs_reg;

  assign cond[COND_MOVING] = moving_i;
  assign cond[COND_FWD] = forward_i;
  assign cond[COND_KEY0 +: NUM_KEYS] = fkey_i;
  assign cond[COND_SENSOR0 +: NUM_SENSORS] = sensor_i;

  // row placement, upper half on the next page
  assign row_page = MAP_PAGE_FIRST + {2'b00, row_reg[4]};

  genvar gc;
  generate
    for (gc = 0; gc < NUM_COND; gc++) begin : g_sat
      assign sat[2*gc] = cond[gc];
      assign sat[2*gc+1] = !cond[gc];
    end
    for (gc = 0; gc < COND_VARS; gc++) begin : g_mask
      assign row_mask[8*gc +: 8] = win_mem[{row_page, row_reg[3:0], 4'(gc)}];
    end
  endgenerate

  assign row_out = win_mem[{row_page, row_reg[3:0], OUT_VAR_PHYS}];
  // all set bits must hold; an empty row never fires
  assign row_hit = (|row_mask) && ((row_mask & ~sat) == '0);

  // one row a cycle, outputs refreshed once a full pass
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      row_reg <= 5'h00;
      acc_reg <= '0;
      outputs_reg <= '0;
    end else begin
      row_reg <= row_reg + 5'h01;
      if (row_reg == 5'(NUM_ROWS - 1)) begin
        // outputs are the union of every hit row
        outputs_reg <= acc_reg | (row_hit ? row_out[NUM_OUTPUTS-1:0] : '0);
        acc_reg <= '0;
      end else if (row_hit) begin
        acc_reg <= acc_reg | row_out[NUM_OUTPUTS-1:0];
      end
    end
  end

  assign front_light_o = outputs_reg[OUT_FRONT];
  assign rear_light_o = outputs_reg[OUT_REAR];
  assign aux_output_one_o = outputs_reg[OUT_AUX_OUTPUT_ONE];
  assign aux_output_two_o = outputs_reg[OUT_AUX2];
  assign aux_output_three_o = outputs_reg[OUT_AUX3];
  assign aux_output_four_o = outputs_reg[OUT_AUX_OUTPUT_FOUR];

  // ********************************************************
  // feature bits and load control
  // ********************************************************
  // serial link enable
  assign serial_extension_link_o = feature_reg[SERIAL_EN_BIT];

  logic [23:0] load_prod;
  assign load_prod = load_corr_i * load_inf_reg;

  // full setting passes unscaled; a shift alone would lose one step
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_corr_o <= 16'h0000;
    end else if (load_inf_reg == LOAD_INF_FULL) begin
      load_corr_o <= load_corr_i;
    end else begin
      load_corr_o <= load_prod[23:8];
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  // an unselected page has no cell of its own, so the top page stands in for it
  logic [10:0] chk_addr;
  logic [7:0] chk_cur;
  logic [10:0] chk_addr_reg;
  assign chk_addr = (page_low_reg <= PAGE_LOW_LAST) ? win_addr : {PAGE_LOW_LAST[2:0], win_addr[7:0]};
  assign chk_cur = win_mem[chk_addr];
  always_ff @(posedge clk_i) begin
    chk_addr_reg <= chk_addr;
  end

  sequence s_low_write;
    cv_wr_i && in_low(cv_num_i) && cv_num_i != CV_PAGE_HIGH && cv_num_i != CV_PAGE_LOW
      && cv_num_i != CV_LOAD_INF && cv_num_i != CV_FEATURE;
  endsequence
  sequence s_same_read;
    cv_rd_i && !cv_wr_i && cv_num_i == $past(cv_num_i);
  endsequence
  sequence s_win_write;
    cv_wr_i && in_window(cv_num_i) && win_ok;
  endsequence

  AST_LOW_FIXED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_low_write ##1 s_same_read |=> cv_rdata_o == $past(cv_wdata_i, 2))
    else $error("low variable read back wrong");
  AST_WIN_READBACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_win_write ##1 s_same_read |=> cv_rdata_o == $past(cv_wdata_i, 2))
    else $error("window variable read back wrong");
  AST_WIN_BAD_INDEX: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cv_wr_i && in_window(cv_num_i) && !win_ok) |=> win_mem[chk_addr_reg] == $past(chk_cur))
    else $error("window changed under bad index");
  AST_WIN_READ_ZERO: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cv_rd_i && in_window(cv_num_i) && !win_ok) |=> cv_rdata_o == 8'h00 && cv_ack_o)
    else $error("unselected page did not read zero");
  AST_SERIAL_EN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cv_wr_i && cv_num_i == CV_FEATURE && cv_wdata_i == 8'h1c) |=> serial_extension_link_o)
    else $error("serial link not enabled");
  AST_LOAD_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (load_inf_reg == 8'h00 && !cv_wr_i) |=> load_corr_o == 16'h0000)
    else $error("load control not disabled");
  AST_LOAD_FULL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (load_inf_reg == LOAD_INF_FULL && !cv_wr_i) |=> load_corr_o == $past(load_corr_i))
    else $error("full load control not passed through");
  AST_SCAN_STEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> row_reg == 5'($past(row_reg) + 5'h01))
    else $error("row scan skipped");
  AST_OUT_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (row_reg != 5'h1f) |=> $stable(outputs_reg))
    else $error("outputs changed mid scan");
  AST_AUX_OUTPUT_FOUR_HIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (row_hit && row_out[OUT_AUX_OUTPUT_FOUR]) |-> ##[1:32] aux_output_four_o)
    else $error("mapped aux four not driven");

endmodule // cfg_map_store

// ### sim/cmd_station_model.sv
module cmd_station_model
  import cfg_map_pkg::*;
(
  // clock
  input wire logic clk_i,
  // variable access toward the store
  output logic [CV_NUM_W-1:0] cv_num_o,
  output logic cv_wr_o,
  output logic cv_rd_o,
  output logic [7:0] cv_wdata_o,
  input wire logic [7:0] cv_rdata_i,
  input wire logic cv_ack_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // late or lingering acknowledges, read by the bench at the end
  int ack_miss = 0;
  // ****************
  // access tasks
  // ****************
  initial begin
    cv_num_o = '0;
    cv_wr_o = 1'b0;
    cv_rd_o = 1'b0;
    cv_wdata_o = '0;
  end
  // one strobe cycle, then the ack is looked at mid-cycle where it is settled
  task automatic xfer(input logic w, input logic [8:0] n, input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cv_num_o <= n;
    cv_wdata_o <= d;
    cv_wr_o <= w;
    cv_rd_o <= !w;
    @(posedge clk_i);
    cv_wr_o <= 1'b0;
    cv_rd_o <= 1'b0;
    // released lines never keep showing the old value
    cv_num_o <= ~n;
    cv_wdata_o <= ~d;
    @(negedge clk_i);
    while (cv_ack_i !== 1'b1 && k < 4) begin
      @(negedge clk_i);
      k++;
    end
    // the answer is due at the very next edge, any wait is a miss
    if (k != 0) begin
      ack_miss++;
    end
    q = cv_rdata_i;
    @(negedge clk_i);
    // ack stands for one cycle only
    if (cv_ack_i !== 1'b0) begin
      ack_miss++;
    end
  endtask
  // write, then read back in the very next cycle; back-to-back traffic is legal
  task automatic wr_rd(input logic [8:0] n, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cv_num_o <= n;
    cv_wdata_o <= d;
    cv_wr_o <= 1'b1;
    @(posedge clk_i);
    cv_wr_o <= 1'b0;
    cv_rd_o <= 1'b1;
    @(posedge clk_i);
    cv_rd_o <= 1'b0;
    @(negedge clk_i);
    q = cv_rdata_i;
  endtask
  task automatic wr(input logic [8:0] n, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, n, d, q);
  endtask
  task automatic rd(input logic [8:0] n, output logic [7:0] q);
    xfer(1'b0, n, 8'h00, q);
  endtask
  task automatic set_page(input logic [7:0] p);
    wr(CV_PAGE_HIGH, PAGE_HIGH_MAP);
    wr(CV_PAGE_LOW, p);
  endtask
  task automatic sine_setup();
    wr(CV_LOAD_INF, 8'h00);
    set_page(8'h02);
    wr(9'h10a, 8'h20);
    wr(9'h11a, 8'h20);
    wr(9'h12a, 8'h20);
    wr(9'h13a, 8'h20);
  endtask
endmodule // cmd_station_model

// ### sim/indexed_config_function_mapping_tb.sv
module indexed_config_function_mapping_tb;
  import cfg_map_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst;
  logic [8:0] num;
  logic wr, rd, ack, ser;
  logic [7:0] wd, rdat, q;
  logic [28:0] fkey;
  logic mv;
  logic fw;
  logic [4:0] sens;
  logic [15:0] lin;
  logic [15:0] lout;
  logic [5:0] outs;
  int n_mismatch = 0;
  int checks = 0;
  // rows: number, data, write, expected read; default rows sit on page 2, so the index moves there first
  logic [25:0] reg_rows [11] = '{{9'h01f, 8'h00, 1'b0, 8'h10}, {9'h020, 8'h00, 1'b0, 8'h00},
    {9'h038, 8'h00, 1'b0, 8'hff}, {9'h07c, 8'h00, 1'b0, 8'h14}, {9'h020, 8'h02, 1'b1, 8'h02},
    {9'h101, 8'h00, 1'b0, 8'h14},
    {9'h10a, 8'h00, 1'b0, 8'h01}, {9'h111, 8'h00, 1'b0, 8'h18}, {9'h11a, 8'h00, 1'b0, 8'h02},
    {9'h000, 8'h55, 1'b1, 8'h00}, {9'h0c8, 8'ha5, 1'b1, 8'ha5}};
  // rows: keys, moving, forward, sensors, expected outputs
  logic [41:0] scan_rows [9] = '{{29'h0, 1'b0, 1'b1, 5'h00, 6'h20}, {29'h0, 1'b1, 1'b1, 5'h00, 6'h20},
    {29'h0, 1'b1, 1'b0, 5'h00, 6'h20}, {29'h4, 1'b0, 1'b1, 5'h00, 6'h2c}, {29'hc, 1'b0, 1'b1, 5'h00, 6'h20},
    {29'h10, 1'b0, 1'b1, 5'h00, 6'h24}, {29'h10000000, 1'b0, 1'b1, 5'h00, 6'h30},
    {29'h0, 1'b0, 1'b1, 5'h10, 6'h30}, {29'h14, 1'b1, 1'b0, 5'h00, 6'h2c}};
  cmd_station_model station (.clk_i(clk), .cv_num_o(num), .cv_wr_o(wr), .cv_rd_o(rd), .cv_wdata_o(wd),
    .cv_rdata_i(rdat), .cv_ack_i(ack));
  cfg_map_store dut (.clk_i(clk), .sys_rst_i(rst), .cv_num_i(num), .cv_wr_i(wr), .cv_rd_i(rd),
    .cv_wdata_i(wd), .cv_rdata_o(rdat), .cv_ack_o(ack), .fkey_i(fkey), .moving_i(mv), .forward_i(fw),
    .sensor_i(sens), .load_corr_i(lin), .load_corr_o(lout), .front_light_o(outs[0]), .rear_light_o(outs[1]),
    .aux_output_one_o(outs[2]), .aux_output_two_o(outs[3]), .aux_output_three_o(outs[4]),
    .aux_output_four_o(outs[5]), .serial_extension_link_o(ser));
  // ****************
  // helpers
  // ****************
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // waits two full scans, outputs may lag up to 64 cycles
  task automatic drive(input logic [28:0] k, input logic m, input logic f, input logic [4:0] s);
    @(posedge clk);
    fkey <= k;
    mv <= m;
    fw <= f;
    sens <= s;
    repeat (70) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly one thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  // ****************
  // tests
  // ****************
  initial begin
    rst <= 1'b1;
    fkey <= '0;
    mv <= 1'b0;
    fw <= 1'b1;
    sens <= '0;
    lin <= '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({9'h0, ser, outs}, 16'h0);
    foreach (reg_rows[i]) begin
      if (reg_rows[i][8])
        station.wr(reg_rows[i][25:17], reg_rows[i][16:9]);
      station.rd(reg_rows[i][25:17], q);
      chk({8'h0, q}, {8'h0, reg_rows[i][7:0]});
    end
    $display("test registers done");
    drive(29'h1, 1'b0, 1'b1, 5'h0);
    chk({10'h0, outs}, 16'h1);
    drive(29'h1, 1'b1, 1'b0, 5'h0);
    chk({10'h0, outs}, 16'h2);
    $display("test lighting done");
    station.set_page(8'h00);
    station.wr(9'h101, 8'h3c);
    station.set_page(8'h02);
    station.rd(9'h101, q);
    chk({8'h0, q}, 16'h14);
    station.set_page(8'h00);
    station.rd(9'h101, q);
    chk({8'h0, q}, 16'h3c);
    station.rd(9'h0c8, q);
    chk({8'h0, q}, 16'ha5);
    station.wr_rd(9'h1ff, 8'h6e, q);
    chk({8'h0, q}, 16'h6e);
    station.wr_rd(9'h0c8, 8'h5a, q);
    chk({8'h0, q}, 16'h5a);
    station.wr(CV_PAGE_HIGH, 8'h11);
    station.wr(9'h101, 8'h77);
    station.rd(9'h101, q);
    chk({8'h0, q}, 16'h0);
    station.set_page(8'h05);
    station.wr(9'h101, 8'h77);
    station.set_page(8'h02);
    station.rd(9'h101, q);
    chk({8'h0, q}, 16'h14);
    $display("test paging done");
    @(posedge clk);
    lin <= 16'h1234;
    repeat (3) @(negedge clk);
    chk(lout, 16'h1234);
    station.wr(CV_LOAD_INF, 8'h80);
    repeat (3) @(negedge clk);
    chk(lout, 16'h091a);
    station.wr(CV_FEATURE, 8'h1c);
    chk({15'h0, ser}, 16'h1);
    station.sine_setup();
    repeat (3) @(negedge clk);
    chk(lout, 16'h0);
    $display("test load and link done");
    station.wr(9'h121, 8'h01);
    station.wr(9'h131, 8'h02);
    station.wr(9'h142, 8'h09);
    station.wr(9'h14a, 8'h0c);
    station.wr(9'h152, 8'h10);
    station.wr(9'h15a, 8'h04);
    station.set_page(8'h03);
    station.wr(9'h108, 8'h10);
    station.wr(9'h10a, 8'h10);
    station.wr(9'h119, 8'h40);
    station.wr(9'h11a, 8'h10);
    foreach (scan_rows[i]) begin
      drive(scan_rows[i][41:13], scan_rows[i][12], scan_rows[i][11], scan_rows[i][10:6]);
      chk({10'h0, outs}, {10'h0, scan_rows[i][5:0]});
    end
    chk(16'(station.ack_miss), 16'h0);
    $display("test mapping done");
    print_verdict();
  end
endmodule // indexed_config_function_mapping_tb
